// ### rtl/uaar_regs.vh
// Register offsets, field positions and constants of the address-recognising serial port
`ifndef UAAR_REGS_VH
`define UAAR_REGS_VH

`define UAAR_ADDR_CTRL      8'h98
`define UAAR_ADDR_SLAVE_ADDRESS_VALUE     8'hA9
`define UAAR_ADDR_SMASK     8'hB9
`define UAAR_ADDR_AUX       8'hA0
`define UAAR_ADDR_IRQSTAT   8'hA1
`define UAAR_ADDR_IRQMASK   8'hA3
`define UAAR_ADDR_RXDATA    8'h99

`define UAAR_CTRL_RESET     8'h00
`define UAAR_BIT_RDONE      0
`define UAAR_BIT_TDONE      1
`define UAAR_BIT_RX9        2
`define UAAR_BIT_TX9        3
`define UAAR_BIT_RXEN       4
`define UAAR_BIT_AMEN       5
`define UAAR_BIT_MODE1      6
`define UAAR_BIT_MODE0      7

`define UAAR_AUX_ERRSEL     0

`define UAAR_IRQ_RDONE      0
`define UAAR_IRQ_TDONE      1
`define UAAR_IRQ_FERR       2
`define UAAR_IRQ_W          3

`define UAAR_MODE_SHIFT     2'b00
`define UAAR_MODE_8BIT      2'b01
`define UAAR_MODE_9FIX      2'b10
`define UAAR_MODE_9VAR      2'b11

`define UAAR_BAUD_DIV       16'h0364
`define UAAR_OVERSAMPLE     4'hF
`define UAAR_HALF_SAMPLE    4'h7

`endif

// ### rtl/uaar_addr_match.v
// Given and broadcast address comparison
`timescale 1ns/1ps
`default_nettype none
module uaar_addr_match #(
    parameter WIDTH = 8
) (
    // Received byte and address set-up
    input  wire [WIDTH-1:0] rxByte,
    input  wire [WIDTH-1:0] slaveAddr,
    input  wire [WIDTH-1:0] slaveMask,
    // Result
    output wire             addrHit
);
    wire [WIDTH-1:0] givenAddr;
    wire [WIDTH-1:0] bcastAddr;
    wire             givenHit;
    wire             bcastHit;

    // Mask zero bits become don't-cares
    assign givenAddr = slaveAddr & slaveMask;
    assign givenHit  = ((rxByte ^ givenAddr) & slaveMask) == {WIDTH{1'b0}};
    // Zero bits of the OR are don't-cares
    assign bcastAddr = slaveAddr | slaveMask;
    assign bcastHit  = ((rxByte ^ bcastAddr) & bcastAddr) == {WIDTH{1'b0}};
    assign addrHit   = givenHit | bcastHit;
endmodule
`default_nettype wire

// ### rtl/uaar_tx.v
// Serial transmitter, done pulse at start of stop bit
`timescale 1ns/1ps
`include "uaar_regs.vh"
`default_nettype none
module uaar_tx #(
    parameter DIV = 16
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Frame request
    input  wire       start,
    input  wire [7:0] txByte,
    input  wire       ninth,
    input  wire       nineBit,
    // Line and status
    output reg        txdPin_ff,
    output reg        busy_ff,
    output reg        stopBegin_ff
);
    reg [15:0] divCnt_ff;
    reg [3:0]  bitIdx_ff;
    reg [10:0] shift_ff;
    wire       tick;
    wire [3:0] lastIdx;

    assign tick    = (divCnt_ff == DIV[15:0] - 16'h0001);
    assign lastIdx = nineBit ? 4'hA : 4'h9;

    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            divCnt_ff    <= 16'h0000;
            bitIdx_ff    <= 4'h0;
            shift_ff     <= 11'h7FF;
            txdPin_ff    <= 1'b1;
            busy_ff      <= 1'b0;
            stopBegin_ff <= 1'b0;
        end
        else
        begin
            stopBegin_ff <= 1'b0;
            if (!busy_ff)
            begin
                txdPin_ff <= 1'b1;
                if (start)
                begin
                    busy_ff   <= 1'b1;
                    divCnt_ff <= 16'h0000;
                    bitIdx_ff <= 4'h0;
                    shift_ff  <= nineBit ? {1'b1, ninth, txByte, 1'b0}
                                         : {2'b11, txByte, 1'b0};
                    txdPin_ff <= 1'b0;
                end
            end
            else if (tick)
            begin
                divCnt_ff <= 16'h0000;
                if (bitIdx_ff == lastIdx)
                    busy_ff <= 1'b0;
                else
                begin
                    bitIdx_ff <= bitIdx_ff + 4'h1;
                    shift_ff  <= {1'b1, shift_ff[10:1]};
                    txdPin_ff <= shift_ff[1];
                    // Stop bit is about to go out
                    if (bitIdx_ff + 4'h1 == lastIdx)
                        stopBegin_ff <= 1'b1;
                end
            end
            else
                divCnt_ff <= divCnt_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### rtl/uaar_core.v
// Address-recognising serial port: control register, receiver, interrupts
`timescale 1ns/1ps
`include "uaar_regs.vh"
`default_nettype none
module uaar_core #(
    parameter DIV_VAR = 16,
    parameter DIV_FIX = 32
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Register port
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrStb,
    input  wire       regRdStb,
    output reg  [7:0] regRdData_ff,
    // Serial line
    input  wire       rxdPin,
    output wire       txdPin,
    // Interrupt
    output reg        irq_ff
);
    localparam RX_IDLE = 2'b00;
    localparam RX_DATA = 2'b01;
    localparam RX_STOP = 2'b10;
    localparam RX_WAIT = 2'b11;

    reg        mode0Bit_ff;
    reg        mode1Bit_ff;
    reg        amEn_ff;
    reg        rxEn_ff;
    reg        tx9_ff;
    reg        rx9_ff;
    reg        tDone_ff;
    reg        rDone_ff;
    reg        ferr_ff;
    reg        errSel_ff;
    reg [7:0]  slaveAddr_ff;
    reg [7:0]  slaveMask_ff;
    reg [7:0]  rxBuf_ff;
    reg [`UAAR_IRQ_W-1:0] irqStat_ff;
    reg [`UAAR_IRQ_W-1:0] irqMask_ff;
    reg [1:0]  rxSync_ff;
    reg [1:0]  rxState_ff;
    reg [15:0] rxDiv_ff;
    reg [3:0]  rxBit_ff;
    reg [8:0]  rxShift_ff;
    reg        txStart_ff;
    // Byte latched with the write, so later bus traffic cannot change it
    reg [7:0]  txData_ff;

    wire [1:0] mode;
    wire       nineBit;
    wire       rxd;
    wire [15:0] divSel;
    wire       rxTick;
    wire       addrHit;
    wire       stopBegin;
    wire       txBusy;
    wire       ctrlWr;
    wire [7:0] ctrlRd;
    reg        rxEvt;
    reg        acceptFrame;
    reg        stopGood;
    reg [`UAAR_IRQ_W-1:0] evtVec;

    // Write decode shared by every writable register
    function wrHit;
        input       stb;
        input [7:0] busAddr;
        input [7:0] regOfs;
        begin
            wrHit = stb && (busAddr == regOfs);
        end
    endfunction

    assign mode    = {mode0Bit_ff, mode1Bit_ff};
    assign nineBit = mode[1];
    assign rxd     = rxSync_ff[1];
    // Fixed-rate nine-bit mode uses its own divider on receive; the transmitter always runs from DIV_VAR
    assign divSel  = (mode == `UAAR_MODE_9FIX) ? DIV_FIX[15:0] : DIV_VAR[15:0];
    assign rxTick  = (rxDiv_ff == divSel - 16'h0001);
    assign ctrlWr  = wrHit(regWrStb, regAddr, `UAAR_ADDR_CTRL);
    // Bit 7 overlay by select bit
    assign ctrlRd  = {(errSel_ff ? ferr_ff : mode0Bit_ff), mode1Bit_ff, amEn_ff, rxEn_ff,
                      tx9_ff, rx9_ff, tDone_ff, rDone_ff};

    uaar_addr_match #(
        .WIDTH (8)
    ) uMatch (
        .rxByte    (rxShift_ff[7:0]),
        .slaveAddr (slaveAddr_ff),
        .slaveMask (slaveMask_ff),
        .addrHit   (addrHit)
    );

    uaar_tx #(
        .DIV (DIV_VAR)
    ) uTx (
        .core_clk     (core_clk),
        .reset        (reset),
        .start        (txStart_ff),
        .txByte       (txData_ff),
        .ninth        (tx9_ff),
        .nineBit      (nineBit),
        .txdPin_ff    (txdPin),
        .busy_ff      (txBusy),
        .stopBegin_ff (stopBegin)
    );

    // Frame acceptance decision at mid stop bit
    always @*
    begin
        stopGood    = rxd;
        acceptFrame = 1'b0;
        rxEvt       = 1'b0;
        if (rxState_ff == RX_STOP && rxTick)
        begin
            rxEvt = 1'b1;
            if (!amEn_ff)
                acceptFrame = nineBit ? 1'b1 : stopGood;
            else if (nineBit)
                acceptFrame = rxShift_ff[8] && addrHit;
            else
                acceptFrame = stopGood && addrHit;
        end
    end

    always @*
    begin
        evtVec = {`UAAR_IRQ_W{1'b0}};
        evtVec[`UAAR_IRQ_RDONE] = acceptFrame;
        evtVec[`UAAR_IRQ_TDONE] = stopBegin && (mode != `UAAR_MODE_SHIFT);
        evtVec[`UAAR_IRQ_FERR]  = rxEvt && !stopGood;
    end

    // Shift mode is not modelled; receiver idles there
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rxSync_ff  <= 2'b11;
            rxState_ff <= RX_IDLE;
            rxDiv_ff   <= 16'h0000;
            rxBit_ff   <= 4'h0;
            rxShift_ff <= 9'h000;
        end
        else
        begin
            rxSync_ff <= {rxSync_ff[0], rxdPin};
            rxDiv_ff  <= rxTick ? 16'h0000 : rxDiv_ff + 16'h0001;
            case (rxState_ff)
                RX_IDLE:
                begin
                    // Half-bit offset so later ticks land mid bit
                    rxDiv_ff <= {1'b0, divSel[15:1]};
                    rxBit_ff <= 4'h0;
                    if (rxEn_ff && !rxd && mode != `UAAR_MODE_SHIFT)
                        rxState_ff <= RX_DATA;
                end
                RX_DATA:
                begin
                    if (rxTick)
                    begin
                        rxBit_ff <= rxBit_ff + 4'h1;
                        // A low pulse shorter than half a bit is no start
                        if (rxBit_ff == 4'h0 && rxd)
                            rxState_ff <= RX_IDLE;
                        if (rxBit_ff != 4'h0)
                            rxShift_ff <= {rxd, rxShift_ff[8:1]};
                        if (rxBit_ff == (nineBit ? 4'h9 : 4'h8))
                            rxState_ff <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (!nineBit && rxBit_ff == 4'h9)
                        rxShift_ff <= {1'b0, rxShift_ff[8:1]};
                    rxBit_ff <= 4'hF;
                    // Low stop bit: the line must rise before a new start
                    if (rxTick && rxd)
                        rxState_ff <= RX_IDLE;
                    else if (rxTick)
                        rxState_ff <= RX_WAIT;
                end
                RX_WAIT:
                begin
                    if (rxd)
                        rxState_ff <= RX_IDLE;
                end
                default:
                    rxState_ff <= RX_IDLE;
            endcase
        end
    end

    // Registers; hardware set wins over software clear
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            {mode0Bit_ff, mode1Bit_ff, amEn_ff, rxEn_ff} <= 4'h0;
            {tx9_ff, rx9_ff, tDone_ff, rDone_ff}         <= 4'h0;
            ferr_ff      <= 1'b0;
            errSel_ff    <= 1'b0;
            slaveAddr_ff <= 8'h00;
            slaveMask_ff <= 8'h00;
            rxBuf_ff     <= 8'h00;
            irqStat_ff   <= {`UAAR_IRQ_W{1'b0}};
            irqMask_ff   <= {`UAAR_IRQ_W{1'b0}};
            txStart_ff   <= 1'b0;
            txData_ff    <= 8'h00;
            regRdData_ff <= 8'h00;
            irq_ff       <= 1'b0;
        end
        else
        begin
            txStart_ff <= 1'b0;
            if (ctrlWr)
            begin
                // Bit 7 writes the error flag when the overlay is selected
                if (errSel_ff)
                    ferr_ff <= regWrData[`UAAR_BIT_MODE0];
                else
                    mode0Bit_ff <= regWrData[`UAAR_BIT_MODE0];
                mode1Bit_ff <= regWrData[`UAAR_BIT_MODE1];
                amEn_ff     <= regWrData[`UAAR_BIT_AMEN];
                rxEn_ff     <= regWrData[`UAAR_BIT_RXEN];
                tx9_ff      <= regWrData[`UAAR_BIT_TX9];
                rx9_ff      <= regWrData[`UAAR_BIT_RX9];
                tDone_ff    <= regWrData[`UAAR_BIT_TDONE];
                rDone_ff    <= regWrData[`UAAR_BIT_RDONE];
            end
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_SLAVE_ADDRESS_VALUE))
                slaveAddr_ff <= regWrData;
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_SMASK))
                slaveMask_ff <= regWrData;
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_AUX))
                errSel_ff <= regWrData[`UAAR_AUX_ERRSEL];
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_IRQMASK))
                irqMask_ff <= regWrData[`UAAR_IRQ_W-1:0];
            // Shift mode is not built; a transmit write there sends nothing
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_RXDATA) && !txBusy
                && mode != `UAAR_MODE_SHIFT)
            begin
                txStart_ff <= 1'b1;
                txData_ff  <= regWrData;
            end
            if (evtVec[`UAAR_IRQ_TDONE])
                tDone_ff <= 1'b1;
            if (acceptFrame)
            begin
                rDone_ff <= 1'b1;
                rxBuf_ff <= rxShift_ff[7:0];
                rx9_ff   <= nineBit ? rxShift_ff[8] : stopGood;
            end
            // Sticky until software writes it; good frames leave it alone
            if (evtVec[`UAAR_IRQ_FERR])
                ferr_ff <= 1'b1;
            if (wrHit(regWrStb, regAddr, `UAAR_ADDR_IRQSTAT))
                irqStat_ff <= (irqStat_ff & ~regWrData[`UAAR_IRQ_W-1:0]) | evtVec;
            else
                irqStat_ff <= irqStat_ff | evtVec;
            irq_ff <= |(irqStat_ff & irqMask_ff);
            if (regRdStb)
            begin
                case (regAddr)
                    `UAAR_ADDR_CTRL:    regRdData_ff <= ctrlRd;
                    `UAAR_ADDR_SLAVE_ADDRESS_VALUE:   regRdData_ff <= slaveAddr_ff;
                    `UAAR_ADDR_SMASK:   regRdData_ff <= slaveMask_ff;
                    `UAAR_ADDR_AUX:     regRdData_ff <= {7'h00, errSel_ff};
                    `UAAR_ADDR_IRQSTAT: regRdData_ff <= {5'h00, irqStat_ff};
                    `UAAR_ADDR_IRQMASK: regRdData_ff <= {5'h00, irqMask_ff};
                    `UAAR_ADDR_RXDATA:  regRdData_ff <= rxBuf_ff;
                    default:            regRdData_ff <= 8'h00;
                endcase
            end
            else
                regRdData_ff <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ### verification/uaar_core_props.sv
// Port assertions for the address-recognising serial port
`timescale 1ns/1ps
`default_nettype none
module uaar_core_props #(
    parameter int DIV_VAR = 16
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regRdData_ff,
    // Serial line and interrupt
    input wire logic       rxdPin,
    input wire logic       txdPin,
    input wire logic       irq_ff
);
    localparam int IDLE_MIN = 13 * DIV_VAR;
    logic [7:0] ctrlSh_ff;
    logic [7:0] maskSh_ff;
    logic       auxSel_ff;
    logic       saWr_ff;
    logic       smWr_ff;
    logic [9:0] highCnt_ff;
    logic       txIdle;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Only software-owned state is mirrored; hardware flags are not predictable here
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrlSh_ff  <= 8'h00;
            maskSh_ff  <= 8'h00;
            auxSel_ff  <= 1'b0;
            saWr_ff    <= 1'b0;
            smWr_ff    <= 1'b0;
            highCnt_ff <= 10'h000;
        end
        else
        begin
            if (regWrStb && regAddr == 8'h98)
                ctrlSh_ff <= regWrData;
            if (regWrStb && regAddr == 8'hA3)
                maskSh_ff <= regWrData;
            if (regWrStb && regAddr == 8'hA0)
                auxSel_ff <= regWrData[0];
            if (regWrStb && regAddr == 8'hA9)
                saWr_ff <= 1'b1;
            if (regWrStb && regAddr == 8'hB9)
                smWr_ff <= 1'b1;
            // Long high run means no frame can be in flight
            if (!txdPin)
                highCnt_ff <= 10'h000;
            else if (highCnt_ff != 10'h3FF)
                highCnt_ff <= highCnt_ff + 10'h001;
        end
    end
    assign txIdle = (highCnt_ff > IDLE_MIN);
    rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData_ff == 8'h00)
        else $error("Read data not zero outside a read");
    addr_reset_a: assert property (regRdStb && regAddr == 8'hA9 && !saWr_ff |=> regRdData_ff == 8'h00)
        else $error("Slave address not zero after reset");
    mask_reset_a: assert property (regRdStb && regAddr == 8'hB9 && !smWr_ff |=> regRdData_ff == 8'h00)
        else $error("Slave mask not zero after reset");
    ctrl_fields_a: assert property (regRdStb && regAddr == 8'h98 |=> regRdData_ff[6:3] == $past(ctrlSh_ff[6:3]))
        else $error("Control fields differ from written value");
    unmapped_zero_a: assert property (regRdStb && regAddr == 8'h55 |=> regRdData_ff == 8'h00)
        else $error("Unmapped read not zero");
    tx_start_a: assert property (regWrStb && regAddr == 8'h99 && txIdle && ctrlSh_ff[7:6] == 2'b01 && !auxSel_ff |-> ##[2:4] !txdPin)
        else $error("No start bit after transmit write");
    shift_quiet_a: assert property (regWrStb && regAddr == 8'h99 && txIdle && ctrlSh_ff[7:6] == 2'b00 && !auxSel_ff |-> ##1 txdPin [*8])
        else $error("Transmit line moved in shift mode");
    irq_masked_a: assert property ($past(maskSh_ff) == 8'h00 |-> !irq_ff)
        else $error("Interrupt high with all sources masked");
    cover property (regWrStb && regAddr == 8'h99);
    cover property ($rose(irq_ff));
    cover property (regRdStb && regAddr == 8'hA9);
endmodule
bind uaar_core uaar_core_props #(.DIV_VAR(DIV_VAR)) i_uaar_core_props (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData_ff(regRdData_ff), .rxdPin(rxdPin), .txdPin(txdPin), .irq_ff(irq_ff));
`default_nettype wire

// ### verification/uaar_peer.sv
// Far-side node of the serial line: sends frames, captures transmitted bytes
`timescale 1ns/1ps
`default_nettype none
module uaar_peer (
    // Clock
    input  wire logic core_clk,
    // Serial line
    output var  logic rxdPin,
    input  wire logic txdPin
);
    initial rxdPin = 1'b1;
    task automatic sendFrame(input logic [7:0] data, input logic nine, input logic ninth,
                             input logic goodStop, input int bitC);
        int i;
        @(posedge core_clk);
        rxdPin <= 1'b0;
        repeat (bitC) @(posedge core_clk);
        for (i = 0; i < 8; i++)
        begin
            rxdPin <= data[i];
            repeat (bitC) @(posedge core_clk);
        end
        if (nine)
        begin
            rxdPin <= ninth;
            repeat (bitC) @(posedge core_clk);
        end
        rxdPin <= goodStop;
        repeat (bitC) @(posedge core_clk);
        // Idle line is pulled high
        rxdPin <= 1'b1;
        repeat (bitC) @(posedge core_clk);
    endtask
    task automatic getByte(input int bitC, output logic [7:0] data);
        int i;
        while (txdPin !== 1'b0)
            @(posedge core_clk);
        repeat (bitC / 2) @(posedge core_clk);
        for (i = 0; i < 8; i++)
        begin
            repeat (bitC) @(posedge core_clk);
            data[i] = txdPin;
        end
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Register-level tests of the address-recognising serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int DV = 16;
    localparam int DF = 32;
    logic       core_clk;
    logic       reset;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrStb;
    logic       regRdStb;
    wire  [7:0] regRdData_ff;
    wire        rxdPin;
    wire        txdPin;
    wire        irq_ff;
    int         errorCnt;
    int         comparisons;
    uaar_core #(.DIV_VAR(DV), .DIV_FIX(DF)) i_uaar_core (.core_clk(core_clk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData_ff(regRdData_ff), .rxdPin(rxdPin), .txdPin(txdPin), .irq_ff(irq_ff));
    uaar_peer i_uaar_peer (.core_clk(core_clk), .rxdPin(rxdPin), .txdPin(txdPin));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge core_clk);
        regWrStb  <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        @(posedge core_clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        @(negedge core_clk);
        d = regRdData_ff;
        chk($sformatf("reg %h", a), d & m, exp);
    endtask
    // Clears flags by rewriting the set-up, then sends one frame
    task automatic rxCase(input logic [7:0] cfg, input logic [7:0] data, input logic nine,
                          input logic ninth, input logic good, input int bitC, input logic hit);
        wr(8'h98, cfg);
        i_uaar_peer.sendFrame(data, nine, ninth, good, bitC);
        repeat (4) @(posedge core_clk);
        rdChk(8'h98, 8'h01, {7'h00, hit});
        if (hit)
            rdChk(8'h99, 8'hFF, data);
    endtask
    task automatic completeRun;
        $display("Mismatches %0d, comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge core_clk);
        errorCnt++;
        completeRun;
    end
    initial
    begin
        logic [7:0] b;
        logic [7:0] addrs [4];
        logic [3:0] nin;
        logic [3:0] hits;
        int         m;
        int         k;
        addrs = '{8'hC2, 8'hC1, 8'hFF, 8'hC2};
        nin = 4'b0111;
        hits = 4'b0101;
        errorCnt = 0;
        comparisons = 0;
        reset = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        repeat (250) @(posedge core_clk);
        rdChk(8'h98, 8'hFF, 8'h00);
        rdChk(8'hA9, 8'hFF, 8'h00);
        rdChk(8'hB9, 8'hFF, 8'h00);
        rdChk(8'h55, 8'hFF, 8'h00);
        // Mode 1 transmit, done flag only once the stop bit begins
        wr(8'h98, 8'h40);
        wr(8'h99, 8'hA5);
        i_uaar_peer.getByte(DV, b);
        chk("tx byte", b, 8'hA5);
        rdChk(8'h98, 8'h02, 8'h00);
        repeat (DV / 2) @(posedge core_clk);
        rdChk(8'h98, 8'h02, 8'h02);
        chk("txd stop", {7'h00, txdPin}, 8'h01);
        // Shift mode is not built: nothing leaves, no done flag
        wr(8'h98, 8'h00);
        repeat (250) @(posedge core_clk);
        wr(8'h99, 8'h3C);
        repeat (200) @(posedge core_clk);
        rdChk(8'h98, 8'h02, 8'h00);
        chk("txd shift", {7'h00, txdPin}, 8'h01);
        // Receive interrupt raised, cleared, then masked
        wr(8'hA3, 8'h01);
        rxCase(8'h50, 8'h3C, 1'b0, 1'b0, 1'b1, DV, 1'b1);
        chk("irq set", {7'h00, irq_ff}, 8'h01);
        wr(8'hA1, 8'h01);
        repeat (2) @(posedge core_clk);
        chk("irq clear", {7'h00, irq_ff}, 8'h00);
        wr(8'hA3, 8'h00);
        rxCase(8'h50, 8'h5A, 1'b0, 1'b0, 1'b1, DV, 1'b1);
        chk("irq masked", {7'h00, irq_ff}, 8'h00);
        rxCase(8'h40, 8'h3C, 1'b0, 1'b0, 1'b1, DV, 1'b0);
        rxCase(8'h50, 8'h3C, 1'b0, 1'b0, 1'b0, DV, 1'b0);
        rdChk(8'hA1, 8'h04, 8'h04);
        // Mode 1 matching: stop bit and address both needed
        wr(8'hA9, 8'hC0);
        wr(8'hB9, 8'hFD);
        rxCase(8'h70, 8'hC2, 1'b0, 1'b0, 1'b0, DV, 1'b0);
        rxCase(8'h70, 8'hC1, 1'b0, 1'b0, 1'b1, DV, 1'b0);
        rxCase(8'h70, 8'hC2, 1'b0, 1'b0, 1'b1, DV, 1'b1);
        rdChk(8'hA1, 8'h04, 8'h04);
        wr(8'hA0, 8'h01);
        rdChk(8'h98, 8'h80, 8'h80);
        wr(8'h98, 8'h70);
        rdChk(8'h98, 8'h80, 8'h00);
        wr(8'hA0, 8'h00);
        // Nine-bit modes: given, miss, broadcast, data frame
        for (m = 0; m < 2; m++)
        begin
            for (k = 0; k < 4; k++)
                rxCase(m ? 8'hF0 : 8'hB0, addrs[k], 1'b1, nin[k], 1'b1, m ? DV : DF, hits[k]);
        end
        rxCase(8'hD0, 8'hC1, 1'b1, 1'b1, 1'b1, DV, 1'b1);
        completeRun;
    end
endmodule
`default_nettype wire
